/* File: logic/gpr_general_regs.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_regs.svh"

module gpr_general_regs (
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire gpr_pkg::gpr_req_t i_req,
  output logic [15:0]            o_rdata,
  output logic                   o_gp_page,
  input  wire logic              i_soft_rst,
  input  wire logic              i_low_power_hold_pin,
  output logic                   o_low_power_hold_pin,
  output logic                   o_low_power_hold_pin_oe,
  output logic                   o_led_drive_high,
  input  wire logic [1:0]        i_port_link_loss,
  output logic                   o_quick_link_loss_pin,
  output logic                   o_quick_link_loss_pin_oe,
  input  wire gpr_pkg::gpr_link_t i_link0,
  input  wire gpr_pkg::gpr_link_t i_link1,
  input  wire logic              i_clk_mute,
  input  wire logic [1:0]        i_phy_recovered_ena,
  input  wire logic [1:0]        i_transmitter_clock_ena,
  output logic                   o_recovered_clock_one_out
);
  import gpr_pkg::*;

  gpr_state_t q_ff;
  gpr_state_t nxt_q;

  // squelch decision for one phy at a given level
  function automatic logic squelched(input gpr_link_t l,
                                     input logic [1:0] lvl);
    logic bad;
    bad = !l.link_up || !l.link_stable;
    case (lvl)
      2'h0: squelched = bad || l.mode_1000_master || l.mode_10 ||
                        l.eee_active;
      2'h1: squelched = bad || (l.eee_active && !l.eee_lp_idle_rx);
      2'h2: squelched = !l.link_up;
      default: squelched = 1'b0;
    endcase
  endfunction : squelched

  function automatic logic [3:0] half_period(input logic [2:0] f);
    case (f)
      3'h1:    half_period = 4'(`GPR_HALF_125);
      3'h2:    half_period = 4'(`GPR_HALF_3125);
      default: half_period = 4'(`GPR_HALF_25);
    endcase
  endfunction : half_period

  gpr_link_t sel_link;
  logic      src_ok;
  logic      clk_ena;
  logic      sq;
  logic [3:0] half;

  always_comb begin
    nxt_q = q_ff;
    sel_link = i_link0;
    src_ok = 1'b0;
    clk_ena = 1'b0;
    sq = 1'b1;
    half = half_period(q_ff.rc_freq);

    // three-stage pin samplers; a change counts when stages 2 and 3 agree
    nxt_q.pin_sync  = {q_ff.pin_sync[1:0], i_low_power_hold_pin};
    nxt_q.mute_sync = {q_ff.mute_sync[1:0], i_clk_mute};
    if (q_ff.pin_sync[2] == q_ff.pin_sync[1]) begin
      nxt_q.pin_level = q_ff.pin_sync[2];
    end
    if (q_ff.mute_sync[2] == q_ff.mute_sync[1]) begin
      nxt_q.mute = q_ff.mute_sync[2];
    end

    // register port: read data valid the cycle after the strobe only
    nxt_q.rdata = 16'h0000;
    if (i_req.wr && i_req.addr == `GPR_PAGE_SEL_ADDR) begin
      if (i_req.wdata == `GPR_PAGE_GP) begin
        nxt_q.gp_page = 1'b1;
      end else if (i_req.wdata == `GPR_PAGE_MAIN) begin
        nxt_q.gp_page = 1'b0;
      end
    end else if (i_req.wr && q_ff.gp_page) begin
      case (i_req.addr)
        `GPR_PIN_LED_ADDR: begin
          nxt_q.rsvd_hi   = i_req.wdata[15:14];
          nxt_q.pin_dir_n = i_req.wdata[`GPR_PIN_DIR_N_BIT];
          nxt_q.pin_dout  = i_req.wdata[`GPR_PIN_DOUT_BIT];
          nxt_q.led_tri   = i_req.wdata[`GPR_LED_TRI_BIT];
        end
        `GPR_LINK_LOSS_ADDR: nxt_q.link_src = i_req.wdata[1:0];
        `GPR_RCLK1_ADDR: begin
          nxt_q.rc_en   = i_req.wdata[`GPR_RCLK_EN_BIT];
          nxt_q.rc_src  = i_req.wdata[`GPR_RCLK_SRC_LSB +: 4];
          nxt_q.rc_freq = i_req.wdata[`GPR_RCLK_FREQ_LSB +: 3];
          nxt_q.rc_sql  = i_req.wdata[`GPR_RCLK_SQL_LSB +: 2];
          nxt_q.rc_sel  = i_req.wdata[`GPR_RCLK_SEL_LSB +: 3];
        end
        default: ;
      endcase
    end
    if (i_req.rd) begin
      if (i_req.addr == `GPR_PAGE_SEL_ADDR) begin
        nxt_q.rdata = q_ff.gp_page ? `GPR_PAGE_GP : `GPR_PAGE_MAIN;
      end else if (q_ff.gp_page) begin
        case (i_req.addr)
          `GPR_PIN_LED_ADDR: begin
            nxt_q.rdata[15:14] = q_ff.rsvd_hi;
            nxt_q.rdata[`GPR_PIN_DIR_N_BIT] = q_ff.pin_dir_n;
            nxt_q.rdata[`GPR_PIN_DOUT_BIT]  = q_ff.pin_dout;
            nxt_q.rdata[`GPR_PIN_DIN_BIT]   = q_ff.pin_level;
            nxt_q.rdata[`GPR_LED_TRI_BIT]   = q_ff.led_tri;
          end
          `GPR_LINK_LOSS_ADDR: nxt_q.rdata[1:0] = q_ff.link_src;
          `GPR_RCLK1_ADDR: begin
            nxt_q.rdata[`GPR_RCLK_EN_BIT] = q_ff.rc_en;
            nxt_q.rdata[`GPR_RCLK_SRC_LSB +: 4]  = q_ff.rc_src;
            nxt_q.rdata[`GPR_RCLK_FREQ_LSB +: 3] = q_ff.rc_freq;
            nxt_q.rdata[`GPR_RCLK_SQL_LSB +: 2]  = q_ff.rc_sql;
            nxt_q.rdata[`GPR_RCLK_SEL_LSB +: 3]  = q_ff.rc_sel;
          end
          default: nxt_q.rdata = 16'h0000;
        endcase
      end
    end

    // hold pin: active-low direction bit
    nxt_q.pin_oe  = !q_ff.pin_dir_n;
    nxt_q.pin_out = q_ff.pin_dout;
    // led high level driven only with tri-state cleared
    nxt_q.led_oe_hi = !q_ff.led_tri;

    case (q_ff.link_src)
      2'h0: begin
        nxt_q.link_loss    = i_port_link_loss[0];
        nxt_q.link_loss_oe = 1'b1;
      end
      2'h1: begin
        nxt_q.link_loss    = i_port_link_loss[1];
        nxt_q.link_loss_oe = 1'b1;
      end
      default: begin
        nxt_q.link_loss    = 1'b0;
        nxt_q.link_loss_oe = 1'b0;
      end
    endcase

    // reserved source codes keep the output silent rather than guess
    if (q_ff.rc_src == 4'h0) begin
      sel_link = i_link0;
      src_ok = 1'b1;
    end else if (q_ff.rc_src == 4'h1) begin
      sel_link = i_link1;
      src_ok = 1'b1;
    end
    case (q_ff.rc_sel)
      3'h1: clk_ena = i_phy_recovered_ena[q_ff.rc_src[0]];
      3'h2: clk_ena = i_transmitter_clock_ena[q_ff.rc_src[0]];
      default: clk_ena = 1'b0;
    endcase
    // reserved select codes park the output low, like a reserved source;
    // otherwise a clock caught high would stay high with no ticks
    if (q_ff.rc_sel != 3'h1 && q_ff.rc_sel != 3'h2) begin
      src_ok = 1'b0;
    end
    sq = q_ff.mute || squelched(sel_link, q_ff.rc_sql);

    // output divider steps on source clock enables
    case (q_ff.st)
      GPR_SQ_OFF: begin
        nxt_q.clk_out = 1'b0;
        nxt_q.div_cnt = 4'h0;
        if (q_ff.rc_en && src_ok) begin
          nxt_q.st = sq ? GPR_SQ_LOW : GPR_SQ_RUN;
        end
      end
      GPR_SQ_LOW: begin
        nxt_q.clk_out = 1'b0;
        nxt_q.div_cnt = 4'h0;
        if (!q_ff.rc_en || !src_ok) begin
          nxt_q.st = GPR_SQ_OFF;
        end else if (!sq) begin
          nxt_q.st = GPR_SQ_RUN;
        end
      end
      GPR_SQ_RUN: begin
        if (!q_ff.rc_en || !src_ok) begin
          nxt_q.st = GPR_SQ_OFF;
          nxt_q.clk_out = 1'b0;
        end else if (sq) begin
          nxt_q.st = GPR_SQ_LOW;
          nxt_q.clk_out = 1'b0;
        end else if (clk_ena) begin
          if (q_ff.div_cnt + 4'h1 >= half) begin
            nxt_q.div_cnt = 4'h0;
            nxt_q.clk_out = !q_ff.clk_out;
          end else begin
            nxt_q.div_cnt = q_ff.div_cnt + 4'h1;
          end
        end
      end
      default: nxt_q.st = GPR_SQ_OFF;
    endcase
  end

  // i_sys_rst is the power-on reset; i_soft_rst is a soft/sticky reset
  // that the page ignores, so configuration survives it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q_ff           <= '0;
      q_ff.rsvd_hi   <= `GPR_RSVD1514_RST;
      q_ff.pin_dir_n <= `GPR_PIN_DIR_N_RST;
      q_ff.pin_dout  <= `GPR_PIN_DOUT_RST;
      q_ff.led_tri   <= `GPR_LED_TRI_RST;
      q_ff.link_src  <= `GPR_LINK_SRC_RST;
      q_ff.rc_en     <= `GPR_RCLK_EN_RST;
      q_ff.rc_src    <= `GPR_RCLK_SRC_RST;
      q_ff.rc_freq   <= `GPR_RCLK_FREQ_RST;
      q_ff.rc_sql    <= `GPR_RCLK_SQL_RST;
      q_ff.rc_sel    <= `GPR_RCLK_SEL_RST;
      q_ff.st        <= GPR_SQ_OFF;
    end else if (i_ce) begin
      q_ff <= nxt_q;
    end
  end

  assign o_rdata                   = q_ff.rdata;
  assign o_gp_page                 = q_ff.gp_page;
  assign o_low_power_hold_pin      = q_ff.pin_out;
  assign o_low_power_hold_pin_oe   = q_ff.pin_oe;
  assign o_led_drive_high          = q_ff.led_oe_hi;
  assign o_quick_link_loss_pin     = q_ff.link_loss;
  assign o_quick_link_loss_pin_oe  = q_ff.link_loss_oe;
  assign o_recovered_clock_one_out = q_ff.clk_out;

  logic unused_soft;
  assign unused_soft = i_soft_rst;
endmodule : gpr_general_regs
`default_nettype wire

/* File: logic/gpr_regs.svh */
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

`define GPR_PAGE_SEL_ADDR   5'h1f
`define GPR_PAGE_GP         16'h0010
`define GPR_PAGE_MAIN       16'h0000
`define GPR_PIN_LED_ADDR    5'h0e
`define GPR_LINK_LOSS_ADDR  5'h13
`define GPR_RCLK1_ADDR      5'h17

`define GPR_PIN_DIR_N_BIT   13
`define GPR_PIN_DOUT_BIT    12
`define GPR_PIN_DIN_BIT     11
`define GPR_LED_TRI_BIT     9
`define GPR_RCLK_EN_BIT     15
`define GPR_RCLK_SRC_LSB    11
`define GPR_RCLK_FREQ_LSB   8
`define GPR_RCLK_SQL_LSB    4
`define GPR_RCLK_SEL_LSB    0

`define GPR_PIN_DIR_N_RST   1'b1
`define GPR_PIN_DOUT_RST    1'b0
`define GPR_RSVD1514_RST    2'h0
`define GPR_LED_TRI_RST     1'b1
`define GPR_LINK_SRC_RST    2'h3
`define GPR_RCLK_EN_RST     1'b0
`define GPR_RCLK_SRC_RST    4'h0
`define GPR_RCLK_FREQ_RST   3'h0
`define GPR_RCLK_SQL_RST    2'h0
`define GPR_RCLK_SEL_RST    3'h0

`define GPR_CLK_MHZ         250
`define GPR_HALF_25         (`GPR_CLK_MHZ / 25 / 2)
`define GPR_HALF_125        1
`define GPR_HALF_3125       4

`endif

/* File: logic/gpr_pkg.sv */
`default_nettype none
package gpr_pkg;
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gpr_req_t;

  typedef struct packed {
    logic link_up;
    logic link_stable;
    logic mode_1000_master;
    logic mode_10;
    logic eee_active;
    logic eee_lp_idle_rx;
  } gpr_link_t;

  typedef enum logic [2:0] {
    GPR_SQ_OFF  = 3'b001,
    GPR_SQ_LOW  = 3'b010,
    GPR_SQ_RUN  = 3'b100
  } gpr_clk_st_t;

  typedef struct packed {
    logic        gp_page;
    logic [1:0]  rsvd_hi;
    logic        pin_dir_n;
    logic        pin_dout;
    logic        led_tri;
    logic [1:0]  link_src;
    logic        rc_en;
    logic [3:0]  rc_src;
    logic [2:0]  rc_freq;
    logic [1:0]  rc_sql;
    logic [2:0]  rc_sel;
    logic [2:0]  pin_sync;
    logic [2:0]  mute_sync;
    logic        pin_level;
    logic        mute;
    logic [15:0] rdata;
    logic [3:0]  div_cnt;
    logic        clk_out;
    gpr_clk_st_t st;
    logic        pin_oe;
    logic        pin_out;
    logic        led_oe_hi;
    logic        link_loss;
    logic        link_loss_oe;
  } gpr_state_t;
endpackage : gpr_pkg
`default_nettype wire

/* File: bench/gpr_general_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gpr_chk (
  input wire logic              i_mclk,
  input wire logic              i_sys_rst,
  input wire logic              i_ce,
  input wire gpr_pkg::gpr_req_t i_req,
  input wire logic [15:0]       o_rdata,
  input wire logic              o_gp_page,
  input wire logic              o_low_power_hold_pin,
  input wire logic              o_low_power_hold_pin_oe,
  input wire logic              o_led_drive_high,
  input wire logic              o_quick_link_loss_pin_oe,
  input wire logic              i_clk_mute,
  input wire logic              o_recovered_clock_one_out
);
  import gpr_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  // a frozen block takes no request, so nothing is judged while ce is low
  default disable iff (i_sys_rst || !i_ce);
  // write on the general page, then a quiet cycle so nothing overrides it
  sequence s_wr(logic [4:0] a);
    o_gp_page && i_req.wr && i_req.addr == a ##1 !i_req.wr;
  endsequence
  chk_page_set: assert property (
    i_req.wr && i_req.addr == 5'h1f && i_req.wdata == 16'h0010
    |=> o_gp_page) else $error("page not selected");
  chk_page_main: assert property (
    i_req.wr && i_req.addr == 5'h1f && i_req.wdata == 16'h0000
    |=> !o_gp_page) else $error("page not left");
  chk_main_rd: assert property (
    !o_gp_page && i_req.rd && i_req.addr != 5'h1f |=> o_rdata == 16'h0)
    else $error("main page read not zero");
  chk_rsvd_rd: assert property (
    o_gp_page && i_req.rd
    && i_req.addr inside {[5'h00:5'h0d], [5'h0f:5'h12], 5'h1e}
    |=> o_rdata == 16'h0) else $error("reserved read not zero");
  chk_pin_dir: assert property (s_wr(5'h0e) |=>
    o_low_power_hold_pin_oe == !$past(i_req.wdata[13], 2)
    && (!o_low_power_hold_pin_oe
        || o_low_power_hold_pin == $past(i_req.wdata[12], 2)))
    else $error("hold pin drive wrong");
  chk_led_drv: assert property (s_wr(5'h0e) |=>
    o_led_drive_high == !$past(i_req.wdata[9], 2))
    else $error("led drive wrong");
  chk_link_oe: assert property (s_wr(5'h13) |=>
    o_quick_link_loss_pin_oe == !$past(i_req.wdata[1], 2))
    else $error("link loss enable wrong");
  chk_mute_low: assert property (
    i_clk_mute [*7] |-> !o_recovered_clock_one_out)
    else $error("clock not muted");
  chk_clk_off: assert property (s_wr(5'h17) ##1 !i_req.wr |=>
    $past(i_req.wdata[15], 3) || !o_recovered_clock_one_out)
    else $error("disabled clock not low");
endmodule : gpr_chk
bind gpr_general_regs gpr_chk i_gpr_chk (
  .i_mclk, .i_sys_rst, .i_ce, .i_req, .o_rdata, .o_gp_page,
  .o_low_power_hold_pin, .o_low_power_hold_pin_oe, .o_led_drive_high,
  .o_quick_link_loss_pin_oe, .i_clk_mute, .o_recovered_clock_one_out
);
`default_nettype wire

/* File: bench/gpr_general_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gpr_general_regs_tb;
  import gpr_pkg::*;
  logic        i_mclk, i_sys_rst, i_soft_rst, i_ce;
  logic        i_low_power_hold_pin, i_clk_mute;
  gpr_req_t    i_req;
  gpr_link_t   i_link0;
  logic [1:0]  i_port_link_loss;
  logic [15:0] o_rdata;
  logic        o_gp_page, o_low_power_hold_pin, o_low_power_hold_pin_oe;
  logic        o_led_drive_high, o_quick_link_loss_pin;
  logic        o_quick_link_loss_pin_oe, o_recovered_clock_one_out;
  int          errors, cmp_count;

  // recovered ticks every cycle on both phys; transmitter ticks on phy 0
  // only, so a wrong select or source shows up in the toggle count
  gpr_general_regs i_gpr_general_regs (
    .i_mclk, .i_sys_rst, .i_ce, .i_req, .o_rdata, .o_gp_page,
    .i_soft_rst, .i_low_power_hold_pin, .o_low_power_hold_pin,
    .o_low_power_hold_pin_oe, .o_led_drive_high, .i_port_link_loss,
    .o_quick_link_loss_pin, .o_quick_link_loss_pin_oe, .i_link0,
    .i_link1(gpr_link_t'(6'h30)), .i_clk_mute,
    .i_phy_recovered_ena(2'b11), .i_transmitter_clock_ena(2'b01),
    .o_recovered_clock_one_out
  );

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task test_done;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk) i_req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk) i_req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_mclk) i_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge i_mclk) i_req.rd <= 1'b0;
    #1 cmp(o_rdata, e);
  endtask : rd

  task t_reset;
    rd(5'h0e, 16'h0);
    wr(5'h1f, 16'h0010);
    rd(5'h1f, 16'h0010);
    rd(5'h0e, 16'h2200);
    rd(5'h13, 16'h0003);
    rd(5'h17, 16'h0000);
  endtask : t_reset

  task t_rsvd;
    for (int a = 0; a < 31; a++) begin
      if (a < 14 || (a > 14 && a < 19) || a == 30) begin
        wr(5'(a), 16'hffff);
        rd(5'(a), 16'h0);
      end
    end
  endtask : t_rsvd

  task t_pin;
    wr(5'h0e, 16'h1000);
    cyc(1);
    cmp(16'({o_low_power_hold_pin_oe, o_low_power_hold_pin,
             o_led_drive_high}), 16'h7);
    @(posedge i_mclk) i_low_power_hold_pin <= 1'b1;
    cyc(6);
    rd(5'h0e, 16'h1800);
    @(posedge i_mclk) i_soft_rst <= 1'b1;
    cyc(4);
    @(posedge i_mclk) i_soft_rst <= 1'b0;
    rd(5'h0e, 16'h1800);
    wr(5'h0e, 16'h2200);
    cyc(1);
    cmp(16'({o_low_power_hold_pin_oe, o_led_drive_high}), 16'h0);
  endtask : t_pin

  task t_link;
    for (int s = 0; s < 4; s++) begin
      wr(5'h13, 16'(s));
      cyc(3);
      cmp(16'({o_quick_link_loss_pin_oe,
               o_quick_link_loss_pin & o_quick_link_loss_pin_oe}),
          s == 0 ? 16'h3 : s == 1 ? 16'h2 : 16'h0);
    end
  endtask : t_link

  // a write while frozen must not land
  task t_ce;
    @(posedge i_mclk) i_ce <= 1'b0;
    wr(5'h13, 16'h0000);
    cyc(2);
    @(posedge i_mclk) i_ce <= 1'b1;
    rd(5'h13, 16'h0003);
  endtask : t_ce

  // 40 cycles is a multiple of every half period, so counts are exact
  task rc(input logic [15:0] w, input logic up, input logic m,
          input int e);
    int   n;
    logic p;
    @(posedge i_mclk) i_link0 <= gpr_link_t'({up, 1'b1, m, 3'b0});
    wr(5'h17, w);
    cyc(12);
    n = 0;
    p = o_recovered_clock_one_out;
    repeat (40) begin
      @(posedge i_mclk);
      #1;
      if (o_recovered_clock_one_out !== p) n++;
      // an unknown output would otherwise pass as a quiet one
      if ($isunknown(o_recovered_clock_one_out)) n += 100;
      p = o_recovered_clock_one_out;
    end
    cmp(16'(n), 16'(e));
  endtask : rc

  task t_clk;
    rc(16'h8131, 1'b1, 1'b0, 40);
    rc(16'h8031, 1'b1, 1'b0, 8);
    rc(16'h8231, 1'b1, 1'b0, 10);
    rc(16'h8131, 1'b0, 1'b0, 40);
    rc(16'h8121, 1'b0, 1'b0, 0);
    rc(16'h8121, 1'b1, 1'b0, 40);
    rc(16'h8101, 1'b1, 1'b1, 0);
    rc(16'h8111, 1'b1, 1'b1, 40);
    rc(16'h0131, 1'b1, 1'b0, 0);
    rc(16'h8921, 1'b0, 1'b0, 40);
    rc(16'h9131, 1'b1, 1'b0, 0);
    rc(16'h8132, 1'b1, 1'b0, 40);
    rc(16'h8932, 1'b1, 1'b0, 0);
    rc(16'h8130, 1'b1, 1'b0, 0);
    @(posedge i_mclk) i_clk_mute <= 1'b1;
    rc(16'h8131, 1'b1, 1'b0, 0);
    @(posedge i_mclk) i_clk_mute <= 1'b0;
  endtask : t_clk

  initial begin
    #80000;
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    i_sys_rst = 1'b1;
    i_soft_rst = 1'b0;
    i_ce = 1'b1;
    i_req = '0;
    i_link0 = '0;
    i_low_power_hold_pin = 1'b0;
    i_clk_mute = 1'b0;
    i_port_link_loss = 2'b01;
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_rsvd();
    t_pin();
    t_link();
    t_ce();
    t_clk();
    wr(5'h1f, 16'h0000);
    rd(5'h13, 16'h0);
    test_done();
  end
endmodule : gpr_general_regs_tb
`default_nettype wire
